// File: logic/rfscfg_pkg.sv
// What this block does
// R1: each serial clock rising edge outside a strobe shifts the data pin into a 24-bit register
// R2: a strobe rising edge copies the shift register into the addressed latch
// R3: host keeps serial clock and data low while strobe is high
// R4: extra leading bits fall off; only the last 24 received are kept
// R5: programming is accepted in standby as well as in operation
// R6: words are 24 bits, msb first; first bit received lands in bit 23
// R7: host sends A, B, C, D words; one word may be resent alone
// R8: address 111 loads the test latch; any nonzero load enables test mode
// R9: test mode holds until reset or an all-zero test word is written
// R10: host should clear the test latch after power-up before other writes
// R11: mode0 bits 1:0 decode the low-noise amp: 00/10 off, 01 low, 11 normal
// R12: mode0 enables: mixer 2, if amp 3, limiter 4, rssi 5, lpf 7, slicer 8
// R13: mode0 bit 6 routes lpf input: 0 demodulator, 1 strength path
// R14: mode0 bits 10:9 set power amp level; nonzero enables transmit modulation
// R15: host keeps oscillator enable bit 11 set unless an external source is used
// R16: mode0 bit 12 enables the whole synthesis loop
// R17: a C-word bit selects feedback divider 256 or 512
// R18: a three-bit C-word field sets acquisition pump gain
// R19: acquisition pump runs only while the loop is unlocked
// R20: mode select pin chooses A or B frequency word for the synthesizer
// R21: standby pin low powers blocks down yet programming continues
// R22: address is word bits 23:21; the other 21 bits are the payload
// R23: all mode0 fields reset to zero, every subsystem disabled
package rfscfg_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_W = 3;
  localparam int PAY_W  = 21;
  localparam int ADDR_HI = 23;
  localparam int ADDR_LO = 21;
  // latch addresses and latch reset value
  localparam logic [2:0] ADDR_A = 3'h0;
  localparam logic [2:0] ADDR_B = 3'h1;
  localparam logic [2:0] ADDR_C = 3'h2;
  localparam logic [2:0] ADDR_D = 3'h3;
  localparam logic [2:0] ADDR_E = 3'h7;
  localparam logic [20:0] LATCH_RST = 21'h00_0000;
  // frequency words
  localparam int FREQ_HI = 21;
  localparam int FREQ_LO = 0;
  // mode0 (D word) fields
  localparam int LNA_HI  = 1;
  localparam int LNA_LO  = 0;
  localparam int MIX_B   = 2;
  localparam int IFA_B   = 3;
  localparam int LIM_B   = 4;
  localparam int RSSI_B  = 5;
  localparam int ROUTE_B = 6;
  localparam int LPF_B   = 7;
  localparam int SLC_B   = 8;
  localparam int PA_HI   = 10;
  localparam int PA_LO   = 9;
  localparam int OSC_B   = 11;
  localparam int PLL_B   = 12;
  localparam int DEV_HI  = 20;
  localparam int DEV_LO  = 13;
  // C word fields
  localparam int SLCTL_B = 15;
  localparam int MM_B    = 16;
  localparam int NDIV_B  = 17;
  localparam int ACQ_HI  = 20;
  localparam int ACQ_LO  = 18;
  // low-noise amp decodes and the power amp off code
  localparam logic [1:0] LNA_LOW  = 2'h1;
  localparam logic [1:0] LNA_NORM = 2'h3;
  localparam logic [1:0] PA_OFF   = 2'h0;
endpackage

// File: logic/rfscfg_shift.sv
`timescale 1ns/1ps
`default_nettype none
// msb-first shift register advanced by a one-cycle enable
module rfscfg_shift #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         shift_en,
  input  wire logic         din,
  output logic [W-1:0]      word
);
  typedef struct packed {
    logic [W-1:0] sh;
  } rfscfg_shift_t;
  rfscfg_shift_t st_r;
  rfscfg_shift_t st_nxt;

  // widths below four cannot hold an address and a payload
  if (W < 4) begin : g_w_check
    $error("shift width too small");
  end

  // older bits fall off the top, so only the last W survive
  always_comb begin
    st_nxt = st_r;
    if (shift_en) begin
      st_nxt.sh = {st_r.sh[W-2:0], din}; // R1 R4 R6
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign word = st_r.sh;
endmodule // rfscfg_shift
`default_nettype wire

// File: logic/rfscfg_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser plus rising-edge detect on the second stage
module rfscfg_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      q,
  output logic      rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } rfscfg_sync_t;
  rfscfg_sync_t st_r;
  rfscfg_sync_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q    = st_r.s2;
  assign rise = st_r.s2 & ~st_r.s3;
endmodule // rfscfg_sync
`default_nettype wire

// File: logic/rfscfg_top.sv
`timescale 1ns/1ps
`default_nettype none
// serial programming port and control latches of the transceiver
module rfscfg_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_strobe,
  input  wire logic        mode_pin,
  input  wire logic        standby_pin,
  input  wire logic        loop_locked,
  output logic [21:0]      synth_freq,
  output logic [7:0]       fsk_deviation,
  output logic             lna_enable,
  output logic             lna_low_gain,
  output logic             mixer_enable,
  output logic             if_amp_enable,
  output logic             limiter_enable_mode0,
  output logic             strength_detector_enable_mode0,
  output logic             demod_route_select_mode0,
  output logic             lowpass_amp_enable_mode0,
  output logic             slicer_enable_mode0,
  output logic [1:0]       power_amp_level_mode0,
  output logic             tx_mod_enable,
  output logic             oscillator_enable_mode0,
  output logic             synth_loop_enable,
  output logic             div_ratio_512,
  output logic             slicer_learn,
  output logic             mod_mode,
  output logic [2:0]       acq_pump_gain,
  output logic             acq_pump_output,
  output logic             test_mode,
  output logic [20:0]      mode1_word
);
  typedef struct packed {
    logic [20:0] lat_a;
    logic [20:0] lat_b;
    logic [20:0] lat_c;
    logic [20:0] lat_d;
    logic [20:0] lat_e;
    logic [21:0] freq;
    logic [7:0]  dev;
    logic        lna_en;
    logic        lna_low;
    logic        mix;
    logic        ifa;
    logic        lim;
    logic        rssi;
    logic        route;
    logic        lpf;
    logic        slc;
    logic [1:0]  pa;
    logic        txmod;
    logic        osc;
    logic        pll;
    logic        ndiv;
    logic        slctl;
    logic        mm;
    logic [2:0]  acq_gain;
    logic        acq;
    logic        tmode;
    logic        lock_s1;
    logic        lock_s2;
    logic        run_s1;
    logic        run_s2;
  } rfscfg_top_t;
  rfscfg_top_t st_r;
  rfscfg_top_t st_nxt;

  // low-noise amp code to {enable, low gain}; codes 00 and 10 both leave it off
  function automatic logic [1:0] lna_decode(input logic [1:0] code);
    logic [1:0] res;
    res = 2'h0;
    case (code)
      rfscfg_pkg::LNA_LOW:  res = 2'h3;
      rfscfg_pkg::LNA_NORM: res = 2'h2;
      default:              res = 2'h0;
    endcase
    return res;
  endfunction

  // low-noise amp field of the D latch
  function automatic logic [1:0] lna_field(input logic [20:0] lat);
    return lat[rfscfg_pkg::LNA_HI:rfscfg_pkg::LNA_LO];
  endfunction

  // amplifier field of the D latch, read by the level and by the modulation gate
  function automatic logic [1:0] pa_field(input logic [20:0] lat);
    return lat[rfscfg_pkg::PA_HI:rfscfg_pkg::PA_LO];
  endfunction

  // any nonzero level also opens the transmit data path
  function automatic logic pa_active(input logic [1:0] code);
    return code != rfscfg_pkg::PA_OFF;
  endfunction

  logic                         mode_q;
  logic [1:0]                   lna_dec;
  logic                         ck_rise;
  logic                         dat_q;
  logic                         stb_q;
  logic                         stb_rise;
  logic [rfscfg_pkg::WORD_W-1:0] sh_word;
  logic [rfscfg_pkg::ADDR_W-1:0] waddr;
  logic [rfscfg_pkg::PAY_W-1:0]  wpay;

  // each pin crosses through two flops before use
  rfscfg_sync u_sync_ck (
    .clk  (clk),
    .srst (srst),
    .din  (ser_clk),
    .q    (),
    .rise (ck_rise)
  );
  rfscfg_sync u_sync_dat (
    .clk  (clk),
    .srst (srst),
    .din  (ser_data),
    .q    (dat_q),
    .rise ()
  );
  rfscfg_sync u_sync_stb (
    .clk  (clk),
    .srst (srst),
    .din  (ser_strobe),
    .q    (stb_q),
    .rise (stb_rise)
  );

  // data is synchronised alongside the clock, so it is stable when the edge is seen;
  // shifting is held off during strobe, where the host keeps both lines low anyway
  rfscfg_shift #(
    .W (rfscfg_pkg::WORD_W)
  ) u_shift (
    .clk      (clk),
    .srst     (srst),
    .shift_en (ck_rise & ~stb_q), // R1 R3
    .din      (dat_q),
    .word     (sh_word)
  );

  // address on top three bits, payload below
  assign waddr = sh_word[rfscfg_pkg::ADDR_HI:rfscfg_pkg::ADDR_LO]; // R22
  assign wpay  = sh_word[rfscfg_pkg::PAY_W-1:0];                  // R22

  // low-noise amp decode feeds two output flops
  assign lna_dec = lna_decode(lna_field(st_r.lat_d)); // R11

  // latch load, field decode and synthesizer selection
  always_comb begin
    st_nxt = st_r;
    // strobe loads regardless of standby; standby only gates the outputs
    if (stb_rise) begin // R2 R5
      case (waddr)
        rfscfg_pkg::ADDR_A: st_nxt.lat_a = wpay;
        rfscfg_pkg::ADDR_B: st_nxt.lat_b = wpay;
        rfscfg_pkg::ADDR_C: st_nxt.lat_c = wpay;
        rfscfg_pkg::ADDR_D: st_nxt.lat_d = wpay;
        rfscfg_pkg::ADDR_E: st_nxt.lat_e = wpay; // R8
        default:            st_nxt.lat_a = st_r.lat_a; // other addresses ignored
      endcase
    end
    // test mode tracks the test latch: nonzero sets, all-zero clears
    st_nxt.tmode = (st_r.lat_e != rfscfg_pkg::LATCH_RST); // R8 R9
    // lock status and standby pin are from outside; sync them
    st_nxt.lock_s1 = loop_locked;
    st_nxt.lock_s2 = st_r.lock_s1;
    st_nxt.run_s1  = standby_pin;
    st_nxt.run_s2  = st_r.run_s1;
    // standby forces every powered enable off; the latches keep their contents
    if (!st_r.run_s2) begin // R21
      st_nxt.lna_en  = 1'h0;
      st_nxt.lna_low = 1'h0;
      st_nxt.mix     = 1'h0;
      st_nxt.ifa     = 1'h0;
      st_nxt.lim     = 1'h0;
      st_nxt.rssi    = 1'h0;
      st_nxt.lpf     = 1'h0;
      st_nxt.slc     = 1'h0;
      st_nxt.pa      = rfscfg_pkg::PA_OFF;
      st_nxt.txmod   = 1'h0;
      st_nxt.osc     = 1'h0;
      st_nxt.pll     = 1'h0;
      st_nxt.acq     = 1'h0;
    end else begin
      st_nxt.lna_en  = lna_dec[1]; // R11
      st_nxt.lna_low = lna_dec[0]; // R11
      st_nxt.mix     = st_r.lat_d[rfscfg_pkg::MIX_B];  // R12
      st_nxt.ifa     = st_r.lat_d[rfscfg_pkg::IFA_B];  // R12
      st_nxt.lim     = st_r.lat_d[rfscfg_pkg::LIM_B];  // R12
      st_nxt.rssi    = st_r.lat_d[rfscfg_pkg::RSSI_B]; // R12
      st_nxt.lpf     = st_r.lat_d[rfscfg_pkg::LPF_B];  // R12
      st_nxt.slc     = st_r.lat_d[rfscfg_pkg::SLC_B];  // R12
      st_nxt.pa      = pa_field(st_r.lat_d);            // R14
      st_nxt.txmod   = pa_active(pa_field(st_r.lat_d)); // R14
      st_nxt.osc     = st_r.lat_d[rfscfg_pkg::OSC_B]; // R15
      st_nxt.pll     = st_r.lat_d[rfscfg_pkg::PLL_B]; // R16
      // acquisition pump only while the loop is enabled and not yet locked
      st_nxt.acq     = st_r.lat_d[rfscfg_pkg::PLL_B] & ~st_r.lock_s2; // R19
    end
    st_nxt.route = st_r.lat_d[rfscfg_pkg::ROUTE_B]; // R13
    st_nxt.dev   = st_r.lat_d[rfscfg_pkg::DEV_HI:rfscfg_pkg::DEV_LO];
    st_nxt.ndiv  = st_r.lat_c[rfscfg_pkg::NDIV_B]; // R17
    st_nxt.slctl = st_r.lat_c[rfscfg_pkg::SLCTL_B];
    st_nxt.mm    = st_r.lat_c[rfscfg_pkg::MM_B];
    st_nxt.acq_gain = st_r.lat_c[rfscfg_pkg::ACQ_HI:rfscfg_pkg::ACQ_LO]; // R18
    // frequency words are 21 payload bits, zero-extended to 22
    st_nxt.freq  = mode_q ? {1'h0, st_r.lat_b} : {1'h0, st_r.lat_a}; // R20
  end

  // mode select pin, synchronised like the serial pins
  rfscfg_sync u_sync_mode (
    .clk  (clk),
    .srst (srst),
    .din  (mode_pin),
    .q    (mode_q),
    .rise ()
  );

  // srst stands in for power-up: every latch and decode returns to zero
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0; // R23 R9
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign synth_freq                     = st_r.freq;
  assign fsk_deviation                  = st_r.dev;
  assign lna_enable                     = st_r.lna_en;
  assign lna_low_gain                   = st_r.lna_low;
  assign mixer_enable                   = st_r.mix;
  assign if_amp_enable                  = st_r.ifa;
  assign limiter_enable_mode0           = st_r.lim;
  assign strength_detector_enable_mode0 = st_r.rssi;
  assign demod_route_select_mode0       = st_r.route;
  assign lowpass_amp_enable_mode0       = st_r.lpf;
  assign slicer_enable_mode0            = st_r.slc;
  assign power_amp_level_mode0          = st_r.pa;
  assign tx_mod_enable                  = st_r.txmod;
  assign oscillator_enable_mode0        = st_r.osc;
  assign synth_loop_enable              = st_r.pll;
  assign div_ratio_512                  = st_r.ndiv;
  assign slicer_learn                   = st_r.slctl;
  assign mod_mode                       = st_r.mm;
  assign acq_pump_gain                  = st_r.acq_gain;
  assign acq_pump_output                = st_r.acq;
  assign test_mode                      = st_r.tmode;
  assign mode1_word                     = st_r.lat_b;
endmodule // rfscfg_top
`default_nettype wire

// File: tb/rfscfg_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches latch and decode results at the top ports
module rfscfg_asserts (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ser_strobe,
  input wire logic        mode_pin,
  input wire logic        standby_pin,
  input wire logic        loop_locked,
  input wire logic [21:0] synth_freq,
  input wire logic [7:0]  fsk_deviation,
  input wire logic        lna_enable,
  input wire logic        lna_low_gain,
  input wire logic        mixer_enable,
  input wire logic [1:0]  power_amp_level_mode0,
  input wire logic        tx_mod_enable,
  input wire logic        synth_loop_enable,
  input wire logic [2:0]  acq_pump_gain,
  input wire logic        acq_pump_output,
  input wire logic        test_mode,
  input wire logic [20:0] mode1_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // reset is the cause here, so it cannot also be the disable
  property p_rst;
    disable iff (1'h0) srst |=> !(mixer_enable | test_mode) && mode1_word == 21'h00_0000;
  endproperty
  a_rst: assert property (p_rst) else $error("latches not cleared");
  // latches move only on a strobe; 6 quiet cycles cover the sync latency
  property p_hold;
    !ser_strobe [*6] |-> $stable(mode1_word) && $stable(acq_pump_gain)
      && $stable(test_mode) && $stable(fsk_deviation);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without strobe");
  property p_freq;
    (!ser_strobe && $stable(mode_pin)) [*8] |-> $stable(synth_freq);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency moved");
  property p_stby;
    !standby_pin [*4] |-> !(mixer_enable | lna_enable | tx_mod_enable | synth_loop_enable);
  endproperty
  a_stby: assert property (p_stby) else $error("enable live in standby");
  property p_pump;
    loop_locked [*4] |-> !acq_pump_output;
  endproperty
  a_pump: assert property (p_pump) else $error("pump on while locked");
  property p_tx;
    tx_mod_enable == (power_amp_level_mode0 != 2'h0);
  endproperty
  a_tx: assert property (p_tx) else $error("modulation enable wrong");
  property p_lna;
    lna_low_gain |-> lna_enable;
  endproperty
  a_lna: assert property (p_lna) else $error("low gain without amp");
  property p_msb;
    synth_freq[21] == 1'h0;
  endproperty
  a_msb: assert property (p_msb) else $error("frequency msb set");
endmodule // rfscfg_asserts
bind rfscfg_top rfscfg_asserts u_chk (
  .clk                   (clk),
  .srst                  (srst),
  .ser_strobe            (ser_strobe),
  .mode_pin              (mode_pin),
  .standby_pin           (standby_pin),
  .loop_locked           (loop_locked),
  .synth_freq            (synth_freq),
  .fsk_deviation         (fsk_deviation),
  .lna_enable            (lna_enable),
  .lna_low_gain          (lna_low_gain),
  .mixer_enable          (mixer_enable),
  .power_amp_level_mode0 (power_amp_level_mode0),
  .tx_mod_enable         (tx_mod_enable),
  .synth_loop_enable     (synth_loop_enable),
  .acq_pump_gain         (acq_pump_gain),
  .acq_pump_output       (acq_pump_output),
  .test_mode             (test_mode),
  .mode1_word            (mode1_word)
);
`default_nettype wire

// File: tb/rfscfg_host.sv
`timescale 1ns/1ps
`default_nettype none
// host of the three-wire bus; each call starts just after a clk edge
module rfscfg_host (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_strobe
);
  // all lines parked low until the first word
  initial begin
    ser_clk = 1'h0;
    ser_data = 1'h0;
    ser_strobe = 1'h0;
  end
  // 160 ns bit: data set, 80 ns later the rising edge, 80 ns later low
  task automatic put_bit(input logic b);
    ser_data <= b;
    repeat (8) @(posedge clk);
    ser_clk <= 1'h1;
    repeat (8) @(posedge clk);
    ser_clk <= 1'h0;
  endtask
  // clock and data stay low around the whole strobe pulse
  task automatic put_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) put_bit(w[i]);
    ser_data <= 1'h0;
    repeat (8) @(posedge clk);
    ser_strobe <= 1'h1;
    repeat (8) @(posedge clk);
    ser_strobe <= 1'h0;
    repeat (8) @(posedge clk);
  endtask
endmodule // rfscfg_host
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// programs words through the host model and checks decoded outputs
module testbench;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic        mode_pin = 1'h0;
  logic        standby_pin = 1'h1;
  logic        loop_locked = 1'h0;
  logic        ser_clk, ser_data, ser_strobe, lna_enable, lna_low_gain, mixer_enable;
  logic        if_amp_enable, limiter_enable_mode0, strength_detector_enable_mode0;
  logic        demod_route_select_mode0, lowpass_amp_enable_mode0, slicer_enable_mode0;
  logic        tx_mod_enable, oscillator_enable_mode0, synth_loop_enable, div_ratio_512;
  logic        slicer_learn, mod_mode, acq_pump_output, test_mode;
  logic [21:0] synth_freq;
  logic [7:0]  fsk_deviation;
  logic [1:0]  power_amp_level_mode0;
  logic [2:0]  acq_pump_gain;
  logic [20:0] mode1_word;
  logic [23:0] w;
  int          err_total = 0;
  int          total_checks = 0;
  // mode0 enables in word order 12,11,8..2
  wire logic [8:0] en = {synth_loop_enable, oscillator_enable_mode0, slicer_enable_mode0,
    lowpass_amp_enable_mode0, demod_route_select_mode0, strength_detector_enable_mode0,
    limiter_enable_mode0, if_amp_enable, mixer_enable};

  rfscfg_top u_dut (
    .clk                            (clk),
    .srst                           (srst),
    .ser_clk                        (ser_clk),
    .ser_data                       (ser_data),
    .ser_strobe                     (ser_strobe),
    .mode_pin                       (mode_pin),
    .standby_pin                    (standby_pin),
    .loop_locked                    (loop_locked),
    .synth_freq                     (synth_freq),
    .fsk_deviation                  (fsk_deviation),
    .lna_enable                     (lna_enable),
    .lna_low_gain                   (lna_low_gain),
    .mixer_enable                   (mixer_enable),
    .if_amp_enable                  (if_amp_enable),
    .limiter_enable_mode0           (limiter_enable_mode0),
    .strength_detector_enable_mode0 (strength_detector_enable_mode0),
    .demod_route_select_mode0       (demod_route_select_mode0),
    .lowpass_amp_enable_mode0       (lowpass_amp_enable_mode0),
    .slicer_enable_mode0            (slicer_enable_mode0),
    .power_amp_level_mode0          (power_amp_level_mode0),
    .tx_mod_enable                  (tx_mod_enable),
    .oscillator_enable_mode0        (oscillator_enable_mode0),
    .synth_loop_enable              (synth_loop_enable),
    .div_ratio_512                  (div_ratio_512),
    .slicer_learn                   (slicer_learn),
    .mod_mode                       (mod_mode),
    .acq_pump_gain                  (acq_pump_gain),
    .acq_pump_output                (acq_pump_output),
    .test_mode                      (test_mode),
    .mode1_word                     (mode1_word)
  );
  rfscfg_host u_host (
    .clk        (clk),
    .ser_clk    (ser_clk),
    .ser_data   (ser_data),
    .ser_strobe (ser_strobe)
  );

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic wr(input logic [23:0] v);
    u_host.put_word(v);
  endtask
  // every mode0 field against the word written, standby high
  task automatic dchk(input logic [23:0] v);
    chk("en", 24'({v[12:11], v[8:2]}), 24'(en));
    chk("pa", 24'(v[10:9]), 24'(power_amp_level_mode0));
    chk("tx", 24'(|v[10:9]), 24'(tx_mod_enable));
    chk("lna", 24'({v[0], v[1:0] == 2'h1}), 24'({lna_enable, lna_low_gain}));
    chk("dev", 24'(v[20:13]), 24'(fsk_deviation));
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    dchk(24'h00_0000);
    wr(24'he0_0000);
    chk("test", 24'h00_0000, 24'(test_mode));
    done("reset");
    // each amp code with all enables set, then each power level alone
    for (int i = 0; i < 8; i++) begin
      w = i < 4 ? {3'h3, 8'h5a, 11'h7ff, 2'(i)} : {3'h3, 10'h000, 2'(i), 9'h000};
      wr(w);
      dchk(w);
    end
    done("mode0");
    // written in standby: gated off, yet kept for operation
    standby_pin <= 1'h0;
    w = {3'h3, 8'h00, 13'h1fff};
    wr(w);
    chk("stby", 24'h00_0080, 24'({en, tx_mod_enable, lna_enable, acq_pump_output}));
    standby_pin <= 1'h1;
    repeat (5) @(posedge clk);
    dchk(w);
    chk("pump", 24'h00_0001, 24'(acq_pump_output));
    loop_locked <= 1'h1;
    repeat (5) @(posedge clk);
    chk("pump", 24'h00_0000, 24'(acq_pump_output));
    done("standby");
    wr({3'h2, 6'h2d, 15'h0000});
    chk("c", 24'h00_002e, 24'({acq_pump_gain, div_ratio_512, slicer_learn, mod_mode}));
    wr({3'h0, 21'h01_2345});
    wr({3'h1, 21'h00_abcd});
    chk("fa", 24'h01_2345, 24'(synth_freq));
    mode_pin <= 1'h1;
    repeat (5) @(posedge clk);
    chk("fb", 24'h00_abcd, 24'(synth_freq));
    done("freq");
    // leading extra ones must fall off the front
    for (int i = 0; i < 5; i++) u_host.put_bit(1'h1);
    wr({3'h1, 21'h00_0001});
    chk("m1", 24'h00_0001, 24'(mode1_word));
    wr({3'h4, 21'h1f_ffff});
    chk("m1", 24'h00_0001, 24'(mode1_word));
    done("shift");
    wr({3'h7, 21'h00_0004});
    chk("test", 24'h00_0001, 24'(test_mode));
    wr({3'h3, 21'h00_0000});
    chk("test", 24'h00_0001, 24'(test_mode));
    // a reset in mid-run stands for a power cycle and leaves test mode too
    srst <= 1'h1;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    repeat (2) @(posedge clk);
    chk("test", 24'h00_0000, 24'(test_mode));
    chk("m1", 24'h00_0000, 24'(mode1_word));
    dchk(24'h00_0000);
    wr({3'h7, 21'h00_0004});
    chk("test", 24'h00_0001, 24'(test_mode));
    wr(24'he0_0000);
    chk("test", 24'h00_0000, 24'(test_mode));
    done("test latch");
    summarize();
  end
endmodule // testbench
`default_nettype wire
